// [hw/wkin_consts.vh]
// wake input block: register offsets, fields, reset values, timing counts
// assumes a 10 MHz pclk and an apb slave with 32-bit data
`ifndef WKIN_CONSTS_VH
`define WKIN_CONSTS_VH

// register byte offsets
`define WKIN_CTRL_OFS      12'h000
`define WKIN_BIAS_OFS      12'h004
`define WKIN_LEVEL_OFS     12'h008
`define WKIN_STAT_OFS      12'h00c

// control register fields
`define WKIN_CTRL_WEN_BIT  0
`define WKIN_CTRL_CYC_BIT  1
`define WKIN_CTRL_BUCK_BIT 2
`define WKIN_CTRL_W        3
`define WKIN_CTRL_RST      3'h0

// bias selector
`define WKIN_BIAS_RST      2'h0
`define WKIN_BIAS_NONE     2'h0
`define WKIN_BIAS_PD       2'h1
`define WKIN_BIAS_PU       2'h2
`define WKIN_BIAS_AUTO     2'h3

// operating modes
`define WKIN_MODE_NORMAL   2'h0
`define WKIN_MODE_STOP     2'h1
`define WKIN_MODE_SLEEP    2'h2
`define WKIN_MODE_FAILSAFE 2'h3

// timing, period in ns
`define WKIN_CLK_NS        100
`define WKIN_FILT_US       16
`define WKIN_FILT_CYC      ((`WKIN_FILT_US * 1000) / `WKIN_CLK_NS)
`define WKIN_INT_US        100
`define WKIN_INT_CYC       ((`WKIN_INT_US * 1000 + `WKIN_CLK_NS - 1) / `WKIN_CLK_NS)
`define WKIN_CNT_W         11

`endif

// [hw/wkin_filter.v]
// wake input filter: level follows raw pin after stable filter time
// assumes pin input already synchronous to pclk
`default_nettype none

module wkin_filter (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       sample_en,
  input  wire       raw_in,
  output reg        level_r
);

`include "wkin_consts.vh"

  reg  [`WKIN_CNT_W-1:0] cnt_r;
  wire [31:0]            filt_last_w;
  wire [`WKIN_CNT_W-1:0] filt_last;

  assign filt_last_w = `WKIN_FILT_CYC - 1;
  assign filt_last   = filt_last_w[`WKIN_CNT_W-1:0];

  // count while raw differs from filtered level
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r   <= {`WKIN_CNT_W{1'b0}};
      level_r <= 1'b0;
    end else if (!sample_en || raw_in == level_r) begin
      cnt_r <= {`WKIN_CNT_W{1'b0}};
    end else if (cnt_r == filt_last) begin
      cnt_r   <= {`WKIN_CNT_W{1'b0}};
      level_r <= raw_in;
    end else begin
      cnt_r <= cnt_r + {{(`WKIN_CNT_W-1){1'b0}}, 1'b1};
    end
  end

endmodule

`default_nettype wire

// [hw/wkin_top.v]
// wake input block top: filter, edge detect, mode actions, apb registers
// assumes mode and cyclic window come from the chip's mode controller
//
// The implementer's own choices: the register offsets and the APB register port.
`default_nettype none

module wkin_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        wake_pin,
  input  wire [1:0]  op_mode,
  input  wire        cyclic_window,
  output reg         int_n,
  output reg         wake_req,
  output reg         restart_req,
  output reg         buck_pwm,
  output reg         pull_up_en,
  output reg         pull_down_en
);

`include "wkin_consts.vh"

  // ==========================================================
  // register bus
  reg [`WKIN_CTRL_W-1:0] ctrl_r;
  reg [1:0]              bias_r;
  reg                    wake_flag_r;
  wire                   wr_en;
  wire                   rd_en;
  wire                   hit;
  wire                   wake_en;
  wire                   cyc_mode;
  wire                   buck_sel;

  function is_mapped;
    input [11:0] a;
    begin
      is_mapped = (a == `WKIN_CTRL_OFS) || (a == `WKIN_BIAS_OFS) ||
                  (a == `WKIN_LEVEL_OFS) || (a == `WKIN_STAT_OFS);
    end
  endfunction

  function mode_awake;
    input [1:0] m;
    begin
      mode_awake = (m == `WKIN_MODE_NORMAL) || (m == `WKIN_MODE_STOP);
    end
  endfunction

  // single-cycle slave, no wait states
  assign pready  = 1'b1;
  assign hit     = is_mapped(paddr);
  assign pslverr = psel & penable & ~hit;
  assign wr_en   = psel & penable & pwrite & hit;
  assign rd_en   = psel & ~penable & ~pwrite;

  assign wake_en  = ctrl_r[`WKIN_CTRL_WEN_BIT];
  assign cyc_mode = ctrl_r[`WKIN_CTRL_CYC_BIT];
  assign buck_sel = ctrl_r[`WKIN_CTRL_BUCK_BIT];

  // ==========================================================
  // filter and edge detect
  wire sense_en;
  wire filt_level;
  reg  filt_prev_r;
  wire edge_evt;
  wire in_stop;
  wire buck_mode_from_pin;

  assign in_stop = (op_mode == `WKIN_MODE_STOP);
  assign buck_mode_from_pin = buck_sel & in_stop;
  assign sense_en = ~cyc_mode | cyclic_window;

  wkin_filter i_wkin_filter (
    .pclk      (pclk),
    .presetn   (presetn),
    .sample_en (sense_en),
    .raw_in    (wake_pin),
    .level_r   (filt_level)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_prev_r <= 1'b0;
    end else begin
      filt_prev_r <= filt_level;
    end
  end

  // pin in buck select role takes no wake action
  assign edge_evt = (filt_level ^ filt_prev_r) & wake_en &
                    ~buck_mode_from_pin;

  wire to_int;
  wire to_wake;
  wire to_rst;
  assign to_int  = edge_evt & mode_awake(op_mode);
  assign to_wake = edge_evt & (op_mode == `WKIN_MODE_SLEEP);
  assign to_rst  = edge_evt & (op_mode == `WKIN_MODE_FAILSAFE);

  // ==========================================================
  // mode actions and buck selection
  reg wake_req_nxt;
  reg restart_req_nxt;
  reg buck_pwm_nxt;

  // requests last one cycle, mode controller latches them
  always @* begin
    wake_req_nxt    = to_wake;
    restart_req_nxt = to_rst;
    if (buck_mode_from_pin) begin
      buck_pwm_nxt = wake_pin;
    end else begin
      buck_pwm_nxt = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_req    <= 1'b0;
      restart_req <= 1'b0;
      buck_pwm    <= 1'b1;
    end else begin
      wake_req    <= wake_req_nxt;
      restart_req <= restart_req_nxt;
      buck_pwm    <= buck_pwm_nxt;
    end
  end

  // ==========================================================
  // interrupt pulse: low phase then enforced high gap
  localparam INT_IDLE = 2'b00;
  localparam INT_LOW  = 2'b01;
  localparam INT_GAP  = 2'b10;

  wire [31:0]            int_load_w;
  wire [`WKIN_CNT_W-1:0] int_load;
  wire [`WKIN_CNT_W-1:0] cnt_one;
  reg  [1:0]             int_state_r;
  reg  [1:0]             int_state_nxt;
  reg  [`WKIN_CNT_W-1:0] int_cnt_r;
  reg  [`WKIN_CNT_W-1:0] int_cnt_nxt;
  reg                    int_pend_r;
  reg                    int_pend_nxt;
  reg                    int_n_nxt;

  assign int_load_w = `WKIN_INT_CYC;
  assign int_load   = int_load_w[`WKIN_CNT_W-1:0];
  assign cnt_one    = {{(`WKIN_CNT_W-1){1'b0}}, 1'b1};

  // later events queue one more pulse
  always @* begin
    int_state_nxt = int_state_r;
    int_cnt_nxt   = int_cnt_r;
    int_pend_nxt  = int_pend_r | to_int;
    int_n_nxt     = int_n;
    case (int_state_r)
      // idle: start at once if pending
      INT_IDLE: begin
        if (int_pend_r || to_int) begin
          int_state_nxt = INT_LOW;
          int_cnt_nxt   = int_load;
          int_pend_nxt  = 1'b0;
          int_n_nxt     = 1'b0;
        end
      end
      // low: release after full pulse
      INT_LOW: begin
        int_cnt_nxt = int_cnt_r - cnt_one;
        if (int_cnt_r == cnt_one) begin
          int_state_nxt = INT_GAP;
          int_cnt_nxt   = int_load;
          int_n_nxt     = 1'b1;
        end
      end
      // gap: hold high before next pulse
      INT_GAP: begin
        int_cnt_nxt = int_cnt_r - cnt_one;
        if (int_cnt_r == cnt_one) begin
          int_state_nxt = INT_IDLE;
        end
      end
      default: begin
        int_state_nxt = INT_IDLE;
        int_cnt_nxt   = {`WKIN_CNT_W{1'b0}};
        int_n_nxt     = 1'b1;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_state_r <= INT_IDLE;
      int_cnt_r   <= {`WKIN_CNT_W{1'b0}};
      int_pend_r  <= 1'b0;
      int_n       <= 1'b1;
    end else begin
      int_state_r <= int_state_nxt;
      int_cnt_r   <= int_cnt_nxt;
      int_pend_r  <= int_pend_nxt;
      int_n       <= int_n_nxt;
    end
  end

  // ==========================================================
  // bias current sources
  reg pull_up_nxt;
  reg pull_down_nxt;

  always @* begin
    pull_up_nxt   = 1'b0;
    pull_down_nxt = 1'b0;
    case (bias_r)
      `WKIN_BIAS_NONE: begin
        pull_up_nxt   = 1'b0;
        pull_down_nxt = 1'b0;
      end
      `WKIN_BIAS_PD: begin
        pull_up_nxt   = 1'b0;
        pull_down_nxt = 1'b1;
      end
      `WKIN_BIAS_PU: begin
        pull_up_nxt   = 1'b1;
        pull_down_nxt = 1'b0;
      end
      // auto follows the filtered level
      `WKIN_BIAS_AUTO: begin
        pull_up_nxt   = filt_level;
        pull_down_nxt = ~filt_level;
      end
      default: begin
        pull_up_nxt   = 1'b0;
        pull_down_nxt = 1'b0;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pull_up_en   <= 1'b0;
      pull_down_en <= 1'b0;
    end else begin
      pull_up_en   <= pull_up_nxt;
      pull_down_en <= pull_down_nxt;
    end
  end

  // ==========================================================
  // register writes and wake flag
  wire                    flag_clr;
  reg  [`WKIN_CTRL_W-1:0] ctrl_nxt;
  reg  [1:0]              bias_nxt;
  reg                     wake_flag_nxt;

  assign flag_clr = wr_en & (paddr == `WKIN_STAT_OFS) & pwdata[0];

  // unmapped offsets change nothing
  always @* begin
    ctrl_nxt      = ctrl_r;
    bias_nxt      = bias_r;
    wake_flag_nxt = wake_flag_r;
    if (wr_en && paddr == `WKIN_CTRL_OFS) begin
      ctrl_nxt = pwdata[`WKIN_CTRL_W-1:0];
    end
    if (wr_en && paddr == `WKIN_BIAS_OFS) begin
      bias_nxt = pwdata[1:0];
    end
    // set wins over clear
    if (edge_evt) begin
      wake_flag_nxt = 1'b1;
    end else if (flag_clr) begin
      wake_flag_nxt = 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r      <= `WKIN_CTRL_RST;
      bias_r      <= `WKIN_BIAS_RST;
      wake_flag_r <= 1'b0;
    end else begin
      ctrl_r      <= ctrl_nxt;
      bias_r      <= bias_nxt;
      wake_flag_r <= wake_flag_nxt;
    end
  end

  // ==========================================================
  // read data, captured in setup phase
  wire        lvl_ok;
  reg  [31:0] prdata_nxt;

  // level reads zero outside normal and stop
  assign lvl_ok = mode_awake(op_mode);

  always @* begin
    prdata_nxt = prdata;
    if (rd_en) begin
      case (paddr)
        `WKIN_CTRL_OFS:  prdata_nxt = {29'h0000_0000, ctrl_r};
        `WKIN_BIAS_OFS:  prdata_nxt = {30'h0000_0000, bias_r};
        `WKIN_LEVEL_OFS: prdata_nxt = {31'h0000_0000,
                                       lvl_ok & wake_pin};
        `WKIN_STAT_OFS:  prdata_nxt = {31'h0000_0000, wake_flag_r};
        default:         prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= prdata_nxt;
    end
  end

endmodule

`default_nettype wire

// [tb/wkin_pin_drv.sv]
// pin model: external switch driving the wake pin
// assumes the bench sets lvl just after a rising pclk edge
`default_nettype none
module wkin_pin_drv (
  input  wire logic pclk,
  input  wire logic lvl,
  output var logic  wake_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // ====
  // contact follows command
  initial wake_pin = 1'b0;
  always @(posedge pclk) begin
    wake_pin <= lvl;
  end
endmodule
`default_nettype wire

// [tb/wkin_checker.sv]
// checker: port timing of the wake input block
// assumes bind onto wkin_top, one clock pclk
`default_nettype none
`include "wkin_consts.vh"
module wkin_checker (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic [1:0] op_mode,
  input wire logic       wake_pin,
  input wire logic       int_n,
  input wire logic       wake_req,
  input wire logic       restart_req,
  input wire logic       buck_pwm,
  input wire logic       pull_up_en,
  input wire logic       pull_down_en
);
  timeunit 1ns;
  timeprecision 1ns;
  int lo_cnt_r;
  int hi_cnt_r;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ====
  // low and high run lengths of int_n
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lo_cnt_r <= 0;
      hi_cnt_r <= 1000;
    end else begin
      lo_cnt_r <= int_n ? 0 : lo_cnt_r + 1;
      hi_cnt_r <= !int_n ? 0 : (hi_cnt_r < 1000 ? hi_cnt_r + 1 : 1000);
    end
  end
  property p_int_low;
    $rose(int_n) |-> lo_cnt_r == 1000;
  endproperty
  a_int_low: assert property (p_int_low)
    else $error("int pulse length wrong");
  property p_int_gap;
    $fell(int_n) |-> hi_cnt_r >= 1000;
  endproperty
  a_int_gap: assert property (p_int_gap)
    else $error("int gap too short");
  property p_wreq;
    wake_req |-> $past(op_mode) == `WKIN_MODE_SLEEP;
  endproperty
  a_wreq: assert property (p_wreq)
    else $error("wake request outside sleep");
  property p_rreq;
    restart_req |-> $past(op_mode) == `WKIN_MODE_FAILSAFE;
  endproperty
  a_rreq: assert property (p_rreq)
    else $error("restart request outside fail-safe");
  property p_pulse;
    wake_req || restart_req |=> !wake_req && !restart_req;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("request longer than one cycle");
  property p_pull;
    !(pull_up_en && pull_down_en);
  endproperty
  a_pull: assert property (p_pull)
    else $error("both bias currents on");
  property p_buck;
    !buck_pwm |-> $past(op_mode) == `WKIN_MODE_STOP;
  endproperty
  a_buck: assert property (p_buck)
    else $error("pfm outside stop");
  property p_buck_follow;
    $fell(buck_pwm) |-> buck_pwm == $past(wake_pin);
  endproperty
  a_buck_follow: assert property (p_buck_follow)
    else $error("buck select not following pin");
endmodule
bind wkin_top wkin_checker i_wkin_checker (.pclk(pclk), .presetn(presetn),
  .op_mode(op_mode), .wake_pin(wake_pin), .int_n(int_n),
  .wake_req(wake_req), .restart_req(restart_req), .buck_pwm(buck_pwm),
  .pull_up_en(pull_up_en), .pull_down_en(pull_down_en));
`default_nettype wire

// [tb/wkin_tb_top.sv]
// testbench: apb access and pin stimulus for the wake input block
// assumes wkin_top, wkin_pin_drv and wkin_checker compiled first
`default_nettype none
`include "wkin_consts.vh"
module wkin_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd_v;
  logic        pready, pslverr, err_v, int_n, wake_req, restart_req;
  logic        buck_pwm, pull_up_en, pull_down_en, wake_pin, lvl = 0, win = 0;
  logic [1:0]  op_mode = 0;
  int          num_errors = 0, cmp_count = 0;
  bit          s;
  always #50 pclk = ~pclk;
  wkin_top i_wkin_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wake_pin(wake_pin), .op_mode(op_mode), .cyclic_window(win),
    .int_n(int_n), .wake_req(wake_req), .restart_req(restart_req),
    .buck_pwm(buck_pwm), .pull_up_en(pull_up_en),
    .pull_down_en(pull_down_en));
  wkin_pin_drv i_wkin_pin_drv (.pclk(pclk), .lvl(lvl), .wake_pin(wake_pin));
  // ====
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input int d);
    int n = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1 && n++ < 50) @(posedge pclk);
    if (pready !== 1'b1) num_errors++;
    rd_v = prdata;
    err_v = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // scan n cycles for int (0), wake (1) or restart (2)
  task automatic wt(input int k, input int n);
    s = 0;
    repeat (n) begin
      @(posedge pclk);
      if (k == 0 ? int_n === 1'b0 : (k == 1 ? wake_req : restart_req) === 1'b1)
        s = 1;
    end
  endtask
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ====
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    apb(0, `WKIN_CTRL_OFS, 0); chk(rd_v, `WKIN_CTRL_RST);
    apb(0, 12'h040, 0); chk({err_v, rd_v[0]}, 2'b10);
    for (int b = 0; b < 4; b++) begin
      apb(1, `WKIN_BIAS_OFS, b);
      repeat (2) @(posedge pclk);
      chk({pull_up_en, pull_down_en}, b == 3 ? 2'b01 : b[1:0]);
    end
    $display("test bias done");
    apb(1, `WKIN_CTRL_OFS, 1);
    lvl <= 1;
    repeat (100) @(posedge pclk);
    lvl <= 0;
    wt(0, 300); chk(s, 0);
    lvl <= 1;
    wt(0, 200); chk(s, 1);
    chk({pull_up_en, pull_down_en}, 2'b10);
    apb(0, `WKIN_LEVEL_OFS, 0); chk(rd_v, 1);
    apb(0, `WKIN_STAT_OFS, 0); chk(rd_v, 1);
    apb(1, `WKIN_STAT_OFS, 1);
    apb(0, `WKIN_STAT_OFS, 0); chk(rd_v, 0);
    repeat (2100) @(posedge pclk);
    chk(int_n, 1);
    apb(0, `WKIN_LEVEL_OFS, 0);
    wt(0, 20);
    chk(s, 0);
    $display("test normal done");
    op_mode <= `WKIN_MODE_SLEEP;
    apb(0, `WKIN_LEVEL_OFS, 0); chk(rd_v, 0);
    lvl <= 0;
    wt(1, 200); chk({s, int_n}, 2'b11);
    op_mode <= `WKIN_MODE_FAILSAFE;
    lvl <= 1;
    wt(2, 200); chk(s, 1);
    $display("test sleep done");
    op_mode <= `WKIN_MODE_NORMAL;
    apb(1, `WKIN_CTRL_OFS, 0);
    lvl <= 0;
    wt(0, 300); chk(s, 0);
    apb(1, `WKIN_CTRL_OFS, 3);
    lvl <= 1;
    wt(0, 300); chk(s, 0);
    win <= 1;
    wt(0, 300); chk(s, 1);
    repeat (2100) @(posedge pclk);
    $display("test sensing done");
    op_mode <= `WKIN_MODE_STOP;
    apb(1, `WKIN_CTRL_OFS, 5);
    lvl <= 0;
    repeat (3) @(posedge pclk);
    chk(buck_pwm, 0);
    lvl <= 1;
    repeat (3) @(posedge pclk);
    chk(buck_pwm, 1);
    $display("test buck done");
    conclude();
  end
  initial begin
    repeat (30000) @(posedge pclk);
    num_errors++;
    conclude();
  end
endmodule
`default_nettype wire
